// ---- design/boot_flash_defines.vh ----
// boot_flash_defines.vh: opcodes, offsets, codes and timing counts.
// included by every design file of the block.
`ifndef BOOT_FLASH_DEFINES_VH
`define BOOT_FLASH_DEFINES_VH

// host register offsets
`define REG_SECT_OVR 9'h116
`define REG_TYPE_OVR 9'h118

// flash opcodes
`define OP_RDID 8'h9F
`define OP_READ 8'h03
`define OP_STAT_STD 8'h05
`define OP_STAT_T4 8'hD7
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_PAGE_PROG 8'h02
`define OP_AUTO_INC 8'hAD
`define OP_BUF_PROG 8'h82
`define OP_ERASE_64K 8'hD8
`define OP_ERASE_4K 8'h20
`define BULK_ERASE_SEQ 32'hC794_809A

// status bit masks
`define STAT_BUSY_MASK 8'h01
`define STAT_DONE_MASK 8'h80

// capacity codes (log2 of bytes)
`define CAP_2MBIT 8'h12
`define CAP_4MBIT 8'h13
`define CAP_8MBIT 8'h14

// sector size as log2 of bytes
`define SHIFT_64K 5'h10
`define SHIFT_4K 5'h0C
`define SHIFT_2K 5'h0B

// programming styles
`define PROG_PAGE 2'h0
`define PROG_AUTO_INC 2'h1
`define PROG_BUFFER 2'h2

// header
`define HDR_MAGIC 8'hA5

// clk_in cycles per sck half period
`define SCK_HALF 3'h4

`endif

// ---- design/boot_flash_type_sequencer.v ----
// boot_flash_type_sequencer.v: identifies the boot flash, loads its image,
// and on command erases it and writes a header.
// assumes: host register and command ports on clk_in; miso from a pin.
`default_nettype none
`include "boot_flash_defines.vh"

//Contract
// [RULE_01] identify flash type from read identification
// [RULE_02] accept 2/4 Mbit; 8 Mbit only types 1-2
// [RULE_03] host writes type and sectors for unknown parts
// [RULE_04] valid overrides make flash operate as known
// [RULE_05] init erases, writes header, then flash recognized
// [RULE_06] host only commands init; rest is automatic
// [RULE_07] sector size per type for erase addressing
// [RULE_08] status opcode 0x05, type 4 uses 0xD7
// [RULE_09] busy mask 0x01, type 4 done 0x80
// [RULE_10] read contents with opcode 0x03
// [RULE_11] write enable 0x06 except type 4
// [RULE_12] page program 0x02 for types 1-2 only
// [RULE_13] type 3 auto-increment program, ends with disable
// [RULE_14] type 4 programs through buffer write
// [RULE_15] type 4 bulk erase sends 0xC794809A
// [RULE_16] dual-page flash configured for 256-byte pages; the code sends no page-size configuration command
// [RULE_17] one chip select, half duplex, boot use
// [RULE_18] flash holds at least 2 Mbit
// [RULE_19] frame: select low, opcode, 24-bit address msb first
// [RULE_20] poll status until complete before next command
module boot_flash_type_sequencer #(
  parameter [15:0] LOAD_BYTES = 16'd1024,
  parameter [7:0] MFR_TYPE1 = 8'h11, // arbitrary identification values
  parameter [7:0] MFR_TYPE2 = 8'h22,
  parameter [7:0] MFR_TYPE3 = 8'h33,
  parameter [7:0] MFR_TYPE4 = 8'h44
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // host register port
  input wire [8:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [15:0] reg_wdata_in,
  output wire [15:0] reg_rdata_out,
  // host command
  input wire init_req_in,
  // master serial port
  output wire spi_sck_out,
  output wire spi_cs_n_out,
  output wire spi_mosi_out,
  input wire spi_miso_in,
  // image stream
  output wire [7:0] load_data_out,
  output wire load_valid_out,
  // status
  output wire [2:0] flash_type_out,
  output wire flash_known_out,
  output wire busy_out,
  output wire init_done_out
);

  localparam [3:0] S_ID = 4'd0;
  localparam [3:0] S_LOAD = 4'd1;
  localparam [3:0] S_READY = 4'd2;
  localparam [3:0] S_E_WREN = 4'd3;
  localparam [3:0] S_E_CMD = 4'd4;
  localparam [3:0] S_E_POLL = 4'd5;
  localparam [3:0] S_P_WREN = 4'd6;
  localparam [3:0] S_P_CMD = 4'd7;
  localparam [3:0] S_P_POLL = 4'd8;
  localparam [3:0] S_P_WRDI = 4'd9;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg miso_s1_q;
  reg miso_s2_q;
  reg [15:0] sect_ovr_q;
  reg [15:0] type_ovr_q;
  reg [15:0] reg_rdata_q;
  reg [3:0] state_q;
  reg issued_q;
  reg [2:0] type_q;
  reg known_q;
  reg init_done_q;
  reg [15:0] sect_cnt_q;
  reg [15:0] sec_idx_q;
  reg aai_second_q;
  reg [23:0] id_q;
  reg [7:0] stat_q;
  reg [7:0] load_data_q;
  reg load_valid_q;
  reg fr_busy_q;
  reg fr_wait_q;
  reg [3:0] fr_pos_q;
  reg [7:0] fr_op_q;
  reg fr_addr_en_q;
  reg [23:0] fr_addr_q;
  reg [2:0] fr_wr_n_q;
  reg [31:0] fr_wbuf_q;
  reg [15:0] fr_rd_q;
  reg eng_start_q;
  reg [7:0] eng_tx_q;
  reg [7:0] tx_sel;
  reg [2:0] auto_type;

  wire eng_done;
  wire [7:0] eng_rx;
  wire [4:0] dec_shift;
  wire [7:0] dec_stat_op;
  wire [7:0] dec_stat_mask;
  wire dec_done_pol;
  wire dec_wren;
  wire [1:0] dec_prog;
  wire [7:0] dec_erase_op;
  wire dec_bulk;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  wire [7:0] id_cap = id_q[7:0];
  wire cap_ok = (id_cap == `CAP_2MBIT) || (id_cap == `CAP_4MBIT) ||
    ((id_cap == `CAP_8MBIT) && ((auto_type == 3'd1) || (auto_type == 3'd2))); // see [RULE_02]
  wire recognized = (auto_type != 3'd0) && cap_ok; // see [RULE_01]
  wire ovr_ok = (type_ovr_q >= 16'd1) && (type_ovr_q <= 16'd4) && (sect_ovr_q != 16'd0); // see [RULE_04]
  wire [4:0] cap_minus_shift = id_cap[4:0] - dec_shift;
  wire [15:0] auto_cnt = 16'h0001 << cap_minus_shift;
  wire [23:0] sec_addr = {8'h00, sec_idx_q} << dec_shift; // see [RULE_07]
  wire stat_hit = (stat_q & dec_stat_mask) != 8'h00;
  wire flash_busy = dec_done_pol ? !stat_hit : stat_hit; // see [RULE_09]
  wire [31:0] hdr_word = {`HDR_MAGIC, 5'h00, type_q, sect_cnt_q};
  wire [3:0] rd_pos = 4'd4 + {1'b0, fr_wr_n_q};
  wire rd_phase = (fr_pos_q == rd_pos);
  wire more = !rd_phase || (fr_rd_q != 16'd0);
  wire fr_end = fr_busy_q && !fr_wait_q && !eng_done && !more;
  wire go = !fr_busy_q && !issued_q;
  wire [15:0] sec_next = sec_idx_q + 16'd1;
  wire [31:0] bulk_seq = `BULK_ERASE_SEQ;

  always @* begin
    auto_type = 3'd0;
    if (id_q[23:16] == MFR_TYPE1) auto_type = 3'd1;
    else if (id_q[23:16] == MFR_TYPE2) auto_type = 3'd2;
    else if (id_q[23:16] == MFR_TYPE3) auto_type = 3'd3;
    else if (id_q[23:16] == MFR_TYPE4) auto_type = 3'd4;
  end

  // opcode, address msb first, data, then read dummies
  always @* begin
    case (fr_pos_q)
      4'd0: tx_sel = fr_op_q; // see [RULE_19]
      4'd1: tx_sel = fr_addr_q[23:16];
      4'd2: tx_sel = fr_addr_q[15:8];
      4'd3: tx_sel = fr_addr_q[7:0];
      default: tx_sel = rd_phase ? 8'h00 : fr_wbuf_q[31:24];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and submodules

  assign reg_rdata_out = reg_rdata_q;
  assign spi_cs_n_out = !fr_busy_q; // see [RULE_17]
  assign load_data_out = load_data_q;
  assign load_valid_out = load_valid_q;
  assign flash_type_out = type_q;
  assign flash_known_out = known_q;
  assign busy_out = (state_q != S_READY);
  assign init_done_out = init_done_q;

  flash_type_decode u_decode (
    .type_in(type_q),
    .sector_shift_out(dec_shift),
    .stat_op_out(dec_stat_op),
    .stat_mask_out(dec_stat_mask),
    .stat_done_pol_out(dec_done_pol),
    .wren_out(dec_wren),
    .prog_kind_out(dec_prog),
    .erase_op_out(dec_erase_op),
    .bulk_out(dec_bulk)
  );

  spi_byte_engine u_engine (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(eng_start_q),
    .tx_byte_in(eng_tx_q),
    .done_out(eng_done),
    .rx_byte_out(eng_rx),
    .miso_in(miso_s2_q),
    .sck_out(spi_sck_out),
    .mosi_out(spi_mosi_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // host registers and pin synchroniser

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
      sect_ovr_q <= 16'h0000;
      type_ovr_q <= 16'h0000;
      reg_rdata_q <= 16'h0000;
    end else begin
      miso_s1_q <= spi_miso_in;
      miso_s2_q <= miso_s1_q;
      if (reg_wr_in && (reg_addr_in == `REG_SECT_OVR)) sect_ovr_q <= reg_wdata_in; // see [RULE_03]
      if (reg_wr_in && (reg_addr_in == `REG_TYPE_OVR)) type_ovr_q <= reg_wdata_in;
      if (reg_addr_in == `REG_SECT_OVR) reg_rdata_q <= sect_ovr_q;
      else if (reg_addr_in == `REG_TYPE_OVR) reg_rdata_q <= type_ovr_q;
      else reg_rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine and sequencer

  task launch;
    input [7:0] op;
    input ae;
    input [23:0] addr;
    input [2:0] wn;
    input [31:0] wd;
    input [15:0] rn;
    begin
      fr_busy_q <= 1'b1;
      fr_pos_q <= 4'd0;
      fr_op_q <= op;
      fr_addr_en_q <= ae;
      fr_addr_q <= addr;
      fr_wr_n_q <= wn;
      fr_wbuf_q <= wd;
      fr_rd_q <= rn;
      issued_q <= 1'b1;
    end
  endtask

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= S_ID;
      issued_q <= 1'b0;
      type_q <= 3'd0;
      known_q <= 1'b0;
      init_done_q <= 1'b0;
      sect_cnt_q <= 16'h0000;
      sec_idx_q <= 16'h0000;
      aai_second_q <= 1'b0;
      id_q <= 24'h00_0000;
      stat_q <= 8'h00;
      load_data_q <= 8'h00;
      load_valid_q <= 1'b0;
      fr_busy_q <= 1'b0;
      fr_wait_q <= 1'b0;
      fr_pos_q <= 4'd0;
      fr_op_q <= 8'h00;
      fr_addr_en_q <= 1'b0;
      fr_addr_q <= 24'h00_0000;
      fr_wr_n_q <= 3'd0;
      fr_wbuf_q <= 32'h0000_0000;
      fr_rd_q <= 16'h0000;
      eng_start_q <= 1'b0;
      eng_tx_q <= 8'h00;
    end else begin
      eng_start_q <= 1'b0;
      load_valid_q <= 1'b0;
      if (fr_busy_q) begin
        if (eng_done) begin
          fr_wait_q <= 1'b0;
          if (rd_phase) begin
            fr_rd_q <= fr_rd_q - 16'd1;
            if (state_q == S_ID) id_q <= {id_q[15:0], eng_rx};
            else if (state_q == S_LOAD) begin
              load_data_q <= eng_rx;
              load_valid_q <= 1'b1;
            end else stat_q <= eng_rx;
          end else begin
            if (fr_pos_q >= 4'd4) fr_wbuf_q <= {fr_wbuf_q[23:0], 8'h00};
            fr_pos_q <= ((fr_pos_q == 4'd0) && !fr_addr_en_q) ? 4'd4 : fr_pos_q + 4'd1;
          end
        end else if (!fr_wait_q) begin
          if (more) begin
            eng_tx_q <= tx_sel;
            eng_start_q <= 1'b1;
            fr_wait_q <= 1'b1;
          end else begin
            fr_busy_q <= 1'b0;
          end
        end
      end
      if (fr_end) issued_q <= 1'b0;
      case (state_q)
        S_ID: begin
          if (go) launch(`OP_RDID, 1'b0, 24'h00_0000, 3'd0, 32'h0000_0000, 16'd3); // see [RULE_01]
          else if (fr_end) begin
            type_q <= recognized ? auto_type : 3'd0;
            known_q <= recognized;
            state_q <= recognized ? S_LOAD : S_READY;
          end
        end
        S_LOAD: begin
          if (go) launch(`OP_READ, 1'b1, 24'h00_0000, 3'd0, 32'h0000_0000, LOAD_BYTES); // see [RULE_10]
          else if (fr_end) state_q <= S_READY;
        end
        S_READY: begin
          // the host's only part in programming is this command
          if (init_req_in && (known_q || ovr_ok)) begin // see [RULE_06]
            if (ovr_ok) begin
              type_q <= type_ovr_q[2:0]; // see [RULE_04]
              sect_cnt_q <= sect_ovr_q;
            end else sect_cnt_q <= auto_cnt;
            sec_idx_q <= 16'h0000;
            aai_second_q <= 1'b0;
            init_done_q <= 1'b0;
            state_q <= S_E_WREN;
          end
        end
        S_E_WREN: begin
          if (!dec_wren) state_q <= S_E_CMD; // see [RULE_11]
          else if (go) launch(`OP_WREN, 1'b0, 24'h00_0000, 3'd0, 32'h0000_0000, 16'd0);
          else if (fr_end) state_q <= S_E_CMD;
        end
        S_E_CMD: begin
          if (go && dec_bulk)
            launch(bulk_seq[31:24], 1'b0, 24'h00_0000, 3'd3, {bulk_seq[23:0], 8'h00}, 16'd0); // see [RULE_15]
          else if (go) launch(dec_erase_op, 1'b1, sec_addr, 3'd0, 32'h0000_0000, 16'd0); // see [RULE_07]
          else if (fr_end) state_q <= S_E_POLL;
        end
        S_E_POLL: begin
          if (go) launch(dec_stat_op, 1'b0, 24'h00_0000, 3'd0, 32'h0000_0000, 16'd1); // see [RULE_08]
          else if (fr_end && !flash_busy) begin // see [RULE_20]
            if (!dec_bulk && (sec_next < sect_cnt_q)) begin
              sec_idx_q <= sec_next;
              state_q <= S_E_WREN;
            end else state_q <= S_P_WREN;
          end
        end
        S_P_WREN: begin
          if (!dec_wren) state_q <= S_P_CMD;
          else if (go) launch(`OP_WREN, 1'b0, 24'h00_0000, 3'd0, 32'h0000_0000, 16'd0); // see [RULE_11]
          else if (fr_end) state_q <= S_P_CMD;
        end
        S_P_CMD: begin
          if (go && (dec_prog == `PROG_AUTO_INC))
            launch(`OP_AUTO_INC, !aai_second_q, 24'h00_0000, 3'd2,
              aai_second_q ? {hdr_word[15:0], 16'h0000} : hdr_word, 16'd0); // see [RULE_13]
          else if (go && (dec_prog == `PROG_BUFFER))
            launch(`OP_BUF_PROG, 1'b1, 24'h00_0000, 3'd4, hdr_word, 16'd0); // see [RULE_14]
          else if (go) launch(`OP_PAGE_PROG, 1'b1, 24'h00_0000, 3'd4, hdr_word, 16'd0); // see [RULE_12]
          else if (fr_end) state_q <= S_P_POLL;
        end
        S_P_POLL: begin
          if (go) launch(dec_stat_op, 1'b0, 24'h00_0000, 3'd0, 32'h0000_0000, 16'd1);
          else if (fr_end && !flash_busy) begin // see [RULE_20]
            if ((dec_prog == `PROG_AUTO_INC) && !aai_second_q) begin
              aai_second_q <= 1'b1;
              state_q <= S_P_CMD;
            end else if (dec_prog == `PROG_AUTO_INC) state_q <= S_P_WRDI;
            else begin
              known_q <= 1'b1; // see [RULE_05]
              init_done_q <= 1'b1;
              state_q <= S_READY;
            end
          end
        end
        S_P_WRDI: begin
          if (go) launch(`OP_WRDI, 1'b0, 24'h00_0000, 3'd0, 32'h0000_0000, 16'd0); // see [RULE_13]
          else if (fr_end) begin
            known_q <= 1'b1; // see [RULE_05]
            init_done_q <= 1'b1;
            state_q <= S_READY;
          end
        end
        default: state_q <= S_READY;
      endcase
    end
  end

endmodule // boot_flash_type_sequencer
`default_nettype wire

// ---- design/flash_type_decode.v ----
// flash_type_decode.v: per-type command set and geometry lookup.
// assumes: type code 1..4 from the sequencer; other codes decode like type 2.
`default_nettype none
`include "boot_flash_defines.vh"

module flash_type_decode (
  // selected type
  input wire [2:0] type_in,
  // command set
  output reg [4:0] sector_shift_out,
  output reg [7:0] stat_op_out,
  output reg [7:0] stat_mask_out,
  output reg stat_done_pol_out,
  output reg wren_out,
  output reg [1:0] prog_kind_out,
  output reg [7:0] erase_op_out,
  output reg bulk_out
);

  always @* begin
    sector_shift_out = `SHIFT_4K;
    stat_op_out = `OP_STAT_STD; // see [RULE_08]
    stat_mask_out = `STAT_BUSY_MASK; // see [RULE_09]
    stat_done_pol_out = 1'b0;
    wren_out = 1'b1; // see [RULE_11]
    prog_kind_out = `PROG_PAGE; // see [RULE_12]
    erase_op_out = `OP_ERASE_4K;
    bulk_out = 1'b0;
    case (type_in)
      3'd1: begin
        sector_shift_out = `SHIFT_64K; // see [RULE_07]
        erase_op_out = `OP_ERASE_64K;
      end
      3'd3: begin
        prog_kind_out = `PROG_AUTO_INC; // see [RULE_13]
      end
      3'd4: begin
        sector_shift_out = `SHIFT_2K; // see [RULE_07]
        stat_op_out = `OP_STAT_T4; // see [RULE_08]
        stat_mask_out = `STAT_DONE_MASK; // see [RULE_09]
        stat_done_pol_out = 1'b1;
        wren_out = 1'b0; // see [RULE_11]
        prog_kind_out = `PROG_BUFFER; // see [RULE_14]
        bulk_out = 1'b1; // see [RULE_15]
      end
      default: begin
        sector_shift_out = `SHIFT_4K;
      end
    endcase
  end

endmodule // flash_type_decode
`default_nettype wire

// ---- design/spi_byte_engine.v ----
// spi_byte_engine.v: shifts a byte out and in, clock idle low,
// data changed on falling edge, msb first.
// assumes: miso_in already synchronised to clk_in.
`default_nettype none
`include "boot_flash_defines.vh"

module spi_byte_engine (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // byte request
  input wire start_in,
  input wire [7:0] tx_byte_in,
  output wire done_out,
  output wire [7:0] rx_byte_out,
  // serial lines
  input wire miso_in,
  output wire sck_out,
  output wire mosi_out
);

  reg act_q;
  reg [2:0] div_q;
  reg [2:0] bit_q;
  reg sck_q;
  reg [7:0] sh_q;
  reg [7:0] rx_q;
  reg done_q;

  assign done_out = done_q;
  assign rx_byte_out = rx_q;
  assign sck_out = sck_q;
  assign mosi_out = sh_q[7];

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      act_q <= 1'b0;
      div_q <= 3'h0;
      bit_q <= 3'h0;
      sck_q <= 1'b0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_in && !act_q) begin
        act_q <= 1'b1;
        sh_q <= tx_byte_in;
        div_q <= 3'h0;
        bit_q <= 3'h0;
        sck_q <= 1'b0;
      end else if (act_q) begin
        if (div_q == `SCK_HALF - 3'h1) begin
          div_q <= 3'h0;
          sck_q <= ~sck_q;
          // sample just before the fall; synchroniser lag fits the high half
          if (sck_q) begin
            rx_q <= {rx_q[6:0], miso_in};
            sh_q <= {sh_q[6:0], 1'b0};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              act_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end else begin
          div_q <= div_q + 3'h1;
        end
      end
    end
  end

endmodule // spi_byte_engine
`default_nettype wire

// ---- verif/boot_flash_type_sequencer_bench.sv ----
// boot_flash_type_sequencer_bench: self-checking bench.
// assumes: model and monitor alongside; 16-byte image.
`default_nettype none
module boot_flash_type_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, init_req_in = 1'b0, t4 = 1'b0;
  logic [8:0] reg_addr_in = 9'h000;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [7:0] mfr = 8'h00, cap = 8'h00;
  wire logic spi_sck_out, spi_cs_n_out, spi_mosi_out, spi_miso_in, load_valid_out;
  wire logic flash_known_out, busy_out, init_done_out;
  wire logic [15:0] reg_rdata_out;
  wire logic [7:0] load_data_out;
  wire logic [2:0] flash_type_out;
  logic [31:0] exp_frame[$], fw;
  logic [7:0] exp_load[$];
  int err_total = 0, tests_run = 0, nb = 0, n;
  always #12.5 clk_in = ~clk_in;
  boot_flash_type_sequencer #(.LOAD_BYTES(16'd16)) u_boot_flash_type_sequencer (.clk_in, .rst_n_in,
    .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .init_req_in, .spi_sck_out, .spi_cs_n_out,
    .spi_mosi_out, .spi_miso_in, .load_data_out, .load_valid_out, .flash_type_out, .flash_known_out,
    .busy_out, .init_done_out);
  spi_flash_model u_spi_flash_model (.sck_in(spi_sck_out), .cs_n_in(spi_cs_n_out), .mosi_in(spi_mosi_out),
    .miso_out(spi_miso_in), .mfr_in(mfr), .dev_in(8'h5C), .cap_in(cap), .t4_in(t4));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // first 32 bits of each frame against the notes
  always @(negedge spi_cs_n_out) begin
    fw = 32'h0000_0000;
    nb = 0;
  end
  always @(posedge spi_sck_out) if (spi_cs_n_out === 1'b0) begin
    if (nb < 32) fw[31 - nb] = spi_mosi_out;
    nb++;
  end
  always @(posedge spi_cs_n_out) if (nb > 0) begin
    if (exp_frame.size() == 0) chk_val(fw, 32'hFFFF_FFFF, "extra frame");
    else chk_val(fw, exp_frame.pop_front(), "frame head");
  end
  always @(posedge clk_in) if (load_valid_out === 1'b1) begin
    if (exp_load.size() == 0) chk_val(load_data_out, 32'hFFFF_FFFF, "extra byte");
    else chk_val(load_data_out, exp_load.pop_front(), "image byte");
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic note(input logic [31:0] f, input int r);
    repeat (r) exp_frame.push_back(f);
  endtask
  task automatic wait_idle();
    int c;
    c = 0;
    repeat (2) @(posedge clk_in);
    while (busy_out !== 1'b0 && c < 40000) begin
      @(posedge clk_in);
      c++;
    end
    chk_val(c < 40000, 1, "ready");
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic reg_wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_chk(input logic [8:0] a, input logic [15:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    repeat (2) @(posedge clk_in);
    #1;
    chk_val(reg_rdata_out, e, "reg read");
  endtask
  task automatic boot(input logic [7:0] m, c, input logic f4, known);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    mfr <= m;
    cap <= c;
    t4 <= f4;
    repeat (20) @(posedge clk_in);
    note(32'h9F00_0000, 1);
    if (known) note(32'h0300_0000, 1);
    for (int k = 0; k < 16 && known; k++) exp_load.push_back(8'(k) ^ 8'h5A);
    rst_n_in <= 1'b1;
    wait_idle();
    chk_val(flash_known_out, known, "known");
  endtask
  task automatic init_cmd();
    @(posedge clk_in);
    init_req_in <= 1'b1;
    @(posedge clk_in);
    init_req_in <= 1'b0;
  endtask
  task automatic erase_notes(input logic [7:0] op, input int cnt, input int shift);
    for (int i = 0; i < cnt; i++) begin
      note(32'h0600_0000, 1);
      note({op, 24'(i << shift)}, 1);
      note(32'h0500_0000, 3);
    end
  endtask
  task automatic run_init(input logic [2:0] ty, input string name);
    init_cmd();
    wait_idle();
    chk_val({flash_known_out, init_done_out, flash_type_out}, {2'b11, ty}, "after init");
    chk_val(exp_frame.size() + exp_load.size(), 0, "leftover");
    $display("test %s done", name);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(82));
    boot(8'h22, 8'h13, 1'b0, 1'b1);
    chk_val(flash_type_out, 2, "auto type");
    reg_chk(9'h116, 16'h0000);
    reg_chk(9'h118, 16'h0000);
    reg_wr(9'h118, 16'h0002);
    reg_wr(9'h116, 16'h0001);
    reg_chk(9'h118, 16'h0002);
    reg_chk(9'h116, 16'h0001);
    reg_chk(9'h100, 16'h0000);
    erase_notes(8'h20, 1, 12);
    note(32'h0600_0000, 1);
    note(32'h0200_0000, 1);
    note(32'h0500_0000, 3);
    run_init(3'h2, "type2_override");
    // 8 Mbit refused for type 3; type 5 override refused
    boot(8'h33, 8'h14, 1'b0, 1'b0);
    chk_val(flash_type_out, 0, "unknown type");
    init_cmd();
    reg_wr(9'h118, 16'h0005);
    reg_wr(9'h116, 16'h0001);
    init_cmd();
    repeat (2) @(posedge clk_in);
    #1;
    chk_val(busy_out, 0, "init refused");
    n = $urandom % 3 + 1;
    reg_wr(9'h118, 16'h0003);
    reg_wr(9'h116, 16'(n));
    erase_notes(8'h20, n, 12);
    note(32'h0600_0000, 1);
    note(32'hAD00_0000, 1);
    note(32'h0500_0000, 3);
    note({8'hAD, 16'(n), 8'h00}, 1);
    note(32'h0500_0000, 3);
    note(32'h0400_0000, 1);
    run_init(3'h3, "type3_override");
    boot(8'h44, 8'h12, 1'b1, 1'b1);
    note(32'hC794_809A, 1);
    note(32'hD700_0000, 3);
    note(32'h8200_0000, 1);
    note(32'hD700_0000, 3);
    run_init(3'h4, "type4_auto");
    boot(8'h11, 8'h14, 1'b0, 1'b1);
    erase_notes(8'hD8, 16, 16);
    note(32'h0600_0000, 1);
    note(32'h0200_0000, 1);
    note(32'h0500_0000, 3);
    run_init(3'h1, "type1_8mbit");
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    chk_val(0, 1, "watchdog");
    end_sim();
  end
endmodule // boot_flash_type_sequencer_bench
`default_nettype wire

// ---- verif/flash_seq_monitor.sv ----
// flash_seq_monitor: port-level assertions.
// assumes: bound into the sequencer, one clock, sync reset.
`default_nettype none
module flash_seq_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // host side
  input wire logic [8:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic init_req_in,
  // serial port
  input wire logic spi_sck_out,
  input wire logic spi_cs_n_out,
  // stream and status
  input wire logic load_valid_out,
  input wire logic [2:0] flash_type_out,
  input wire logic flash_known_out,
  input wire logic busy_out,
  input wire logic init_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  sck_idle_a: assert property (spi_cs_n_out |-> !spi_sck_out)
    else $error("sck outside frame");
  cs_lead_a: assert property ($fell(spi_cs_n_out) |-> !spi_sck_out [*4])
    else $error("sck too soon");
  sck_high_a: assert property ($rose(spi_sck_out) |-> spi_sck_out [*4] ##1 !spi_sck_out)
    else $error("sck high half wrong");
  // reset must win mid-frame, so not disabled by it
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n_in |=> spi_cs_n_out && !load_valid_out && !flash_known_out)
    else $error("not quiet in reset");
  rdata_zero_a: assert property ((reg_addr_in != 9'h116 && reg_addr_in != 9'h118) |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read nonzero");
  ovr_read_a: assert property (reg_wr_in && reg_addr_in == 9'h118 ##1 !reg_wr_in && reg_addr_in == 9'h118
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("type readback wrong");
  init_go_a: assert property (init_req_in && !busy_out && flash_known_out |=> busy_out && !init_done_out)
    else $error("init not taken");
  init_end_a: assert property ($rose(init_done_out) |-> !busy_out && flash_known_out)
    else $error("init end unknown");
  known_type_a: assert property (flash_known_out |-> flash_type_out inside {[3'h1:3'h4]})
    else $error("known type out of range");
  load_pulse_a: assert property (load_valid_out |-> busy_out ##1 !load_valid_out)
    else $error("load strobe not a pulse");
  init_cv: cover property (init_req_in && !busy_out && flash_known_out);
  done_cv: cover property ($rose(init_done_out));
  load_cv: cover property (load_valid_out);
endmodule // flash_seq_monitor
bind boot_flash_type_sequencer flash_seq_monitor u_flash_seq_monitor (.clk_in, .rst_n_in, .reg_addr_in,
  .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .init_req_in, .spi_sck_out, .spi_cs_n_out, .load_valid_out,
  .flash_type_out, .flash_known_out, .busy_out, .init_done_out);
`default_nettype wire

// ---- verif/spi_flash_model.sv ----
// spi_flash_model: behavioural serial flash answering id, read and status frames.
// assumes: mode 0 master; busy for two polls after program or erase.
`default_nettype none
module spi_flash_model (
  // serial lines
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  // identity and flavour
  input wire logic [7:0] mfr_in,
  input wire logic [7:0] dev_in,
  input wire logic [7:0] cap_in,
  input wire logic t4_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_q, tx_q, op_q;
  logic [23:0] addr_q;
  int nbit, nbyte, pend;
  initial begin
    miso_out = 1'b0;
    pend = 0;
  end
  // 256-byte pages: plain byte addresses
  function automatic logic [7:0] next_byte();
    case (op_q)
      8'h9F: return nbyte == 1 ? mfr_in : (nbyte == 2 ? dev_in : cap_in);
      8'h03: return 8'(addr_q + 24'(nbyte - 4)) ^ 8'h5A;
      8'h05, 8'hD7: return t4_in ? {pend == 0, 7'h00} : {7'h00, pend > 0};
      default: return 8'h00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge cs_n_in) begin
    nbit = 0;
    nbyte = 0;
    tx_q = 8'h00;
  end
  always @(posedge sck_in) if (!cs_n_in) begin
    sh_q = {sh_q[6:0], mosi_in};
    nbit++;
    if (nbit == 8) begin
      nbit = 0;
      nbyte++;
      if (nbyte == 1) op_q = sh_q;
      else if (nbyte <= 4) addr_q = {addr_q[15:0], sh_q};
      tx_q = next_byte();
    end
  end
  always @(negedge sck_in) if (!cs_n_in) miso_out = tx_q[7 - nbit];
  // released line inverts so a stale bit never passes
  always @(posedge cs_n_in) begin
    miso_out = ~miso_out;
    if (op_q inside {8'h05, 8'hD7} && pend > 0) pend--;
    if (op_q inside {8'hD8, 8'h20, 8'h02, 8'hAD, 8'h82, 8'hC7}) pend = 2;
    op_q = 8'h00;
  end
endmodule // spi_flash_model
`default_nettype wire
